/* host_bus_ready_decode.sv */
// Host bus select decode, ready generation and interrupt pin
`timescale 1ns/1ps
`include "host_bus_regs.svh"
module host_bus_ready_decode
   import host_bus_pkg::*;
#(
   parameter int IRQ_BITS = 16
) (
   input  wire logic                          clk_sys_i,
   input  wire logic                          rst_i,
   input  wire logic                          bus_clk_i,
   input  wire logic [`ADDR_MSB:`ADDR_LSB]    address_i,
   input  wire logic                          address_qualifier_n_i,
   input  wire logic                          address_strobe_n_i,
   input  wire logic                          async_read_strobe_n_i,
   input  wire logic                          async_write_strobe_n_i,
   input  wire logic                          command_cycle_n_i,
   input  wire logic                          sync_write_not_read_i,
   input  wire logic                          bus_mode_strap_n_i,
   input  wire logic                          burst_select_i,
   input  wire logic [15:0]                   base_address_i,
   input  wire logic [IRQ_BITS-1:0]           irq_status_i,
   input  wire logic                          access_done_i,
   output logic                               local_select_n_o,
   output logic                               local_select_n_oe_o,
   output logic                               irq_out_n_o,
   output logic                               irq_out_n_oe_o,
   output logic                               async_ready_o,
   output logic                               async_ready_oe_o,
   output logic                               sync_ready_n_o,
   output logic                               extended_burst_mode_o,
   output logic                               sync_local_bus_mode_o,
   output logic                               access_write_o,
   output logic [`ADDR_MSB:`ADDR_LSB]         latched_address_o,
   output logic                               latched_qualifier_n_o
);
   localparam int AW = `ADDR_MSB - `ADDR_LSB + 1;
   localparam int SW = AW + 7;

   logic [SW-1:0] pins_raw;
   logic [SW-1:0] pins_s;
   logic [AW-1:0] addr_s;
   logic          aq_n_s;
   logic          ads_n_s;
   logic          rd_n_s;
   logic          wr_n_s;
   logic          cyc_n_s;
   logic          swr_s;
   logic          bclk_s;
   logic          bclk_d1_q;
   logic          ads_d1_q;
   logic          bclk_rise;
   logic          ads_rise;
   logic          sel_s;
   logic          strap_q;
   logic          strap_taken_q;
   logic          pend_q;
   logic          pend_clr;
   logic          async_active;
   logic          burst_mode;
   sync_state_e   state_q;
   sync_state_e   state_d;

   assign pins_raw = {address_i, address_qualifier_n_i, address_strobe_n_i, async_read_strobe_n_i,
                      async_write_strobe_n_i, command_cycle_n_i, sync_write_not_read_i, bus_clk_i};

   pin_sync #(
      .WIDTH   (SW),
      .RST_VAL ({{AW{1'b0}}, 7'h7C})
   ) u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     (pins_raw),
      .sync_o    (pins_s)
   );

   assign {addr_s, aq_n_s, ads_n_s, rd_n_s, wr_n_s, cyc_n_s, swr_s, bclk_s} = pins_s;

   // pure gate path from the pins, no flop
   assign local_select_n_o    = !(!address_qualifier_n_i &&
                                  (address_i[`ADDR_MSB:`DECODE_LSB] == base_address_i[15:`DECODE_LSB]));
   assign local_select_n_oe_o = 1'b1;

   // Synchronised copy of the decode for the ready logic
   assign sel_s = !aq_n_s && (addr_s[AW-1:`DECODE_LSB-`ADDR_LSB] == base_address_i[15:`DECODE_LSB]);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bclk_d1_q <= 1'b0;
         ads_d1_q  <= 1'b1;
      end else begin
         bclk_d1_q <= bclk_s;
         ads_d1_q  <= ads_n_s;
      end
   end
   assign bclk_rise = bclk_s && !bclk_d1_q;
   assign ads_rise  = ads_n_s && !ads_d1_q;

   // strap caught once after reset release
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         strap_q       <= `STRAP_SYNC_MODE;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_q       <= bus_mode_strap_n_i;
         strap_taken_q <= 1'b1;
      end
   end

   assign burst_mode            = strap_q && burst_select_i;
   assign sync_local_bus_mode_o = strap_taken_q && (strap_q == `STRAP_SYNC_MODE);
   assign extended_burst_mode_o = strap_taken_q && burst_mode;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         latched_address_o     <= '0;
         latched_qualifier_n_o <= 1'b1;
      end else if (ads_rise) begin
         latched_address_o     <= addr_s;
         latched_qualifier_n_o <= aq_n_s;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         access_write_o <= 1'b0;
      end else if (bclk_rise && state_q == ST_IDLE) begin
         access_write_o <= burst_mode ? !cyc_n_s : swr_s;
      end else if (async_active) begin
         access_write_o <= !wr_n_s;
      end
   end

   // Completion may pulse between bus clock edges, so hold it; set wins over clear
   assign pend_clr = (bclk_rise && (state_q == ST_WAIT || state_q == ST_BURST)) ||
                     (strap_q && !burst_mode && !async_active);
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
      end else if (access_done_i) begin
         pend_q <= 1'b1;
      end else if (pend_clr) begin
         pend_q <= 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (!strap_taken_q) begin
               state_d = ST_IDLE;
            end else if (!strap_q && sel_s && !cyc_n_s) begin
               state_d = ST_WAIT;
            end else if (burst_mode && sel_s && !ads_n_s) begin
               state_d = ST_BURST;
            end
         end
         ST_WAIT: begin
            if (pend_q) begin
               state_d = ST_READY;
            end
         end
         ST_READY: begin
            state_d = ST_IDLE;
         end
         ST_BURST: begin
            if (!sel_s) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state and ready move only on bus clock rises
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else if (bclk_rise) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sync_ready_n_o <= `SYNC_READY_RST;
      end else if (bclk_rise) begin
         // low for each burst wait state
         sync_ready_n_o <= !((state_d == ST_READY) || (state_d == ST_BURST && !pend_q));
      end
   end

   // async access runs on the system clock only
   assign async_active = strap_taken_q && strap_q && !burst_mode && sel_s && (!rd_n_s || !wr_n_s);

   // pull ready low until the transfer can finish
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         async_ready_oe_o <= 1'b0;
      end else begin
         async_ready_oe_o <= async_active && !pend_q && !access_done_i;
      end
   end
   assign async_ready_o = 1'b0;

   // open-drain interrupt low while any status bit set
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         irq_out_n_oe_o <= 1'b0;
      end else begin
         irq_out_n_oe_o <= |irq_status_i;
      end
   end
   assign irq_out_n_o = 1'b0;

   // Assertions
   property p_irq_follow;
      @(posedge clk_sys_i) disable iff (rst_i)
      (|irq_status_i) |=> irq_out_n_oe_o;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq not driven low");

   property p_irq_release;
      @(posedge clk_sys_i) disable iff (rst_i)
      !(|irq_status_i) |=> !irq_out_n_oe_o;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("irq not released");

   property p_select;
      @(posedge clk_sys_i) disable iff (rst_i)
      local_select_n_o == !(!address_qualifier_n_i &&
                            (address_i[`ADDR_MSB:`DECODE_LSB] == base_address_i[15:`DECODE_LSB]));
   endproperty
   a_select: assert property (p_select) else $error("select decode wrong");

   property p_qual_blocks;
      @(posedge clk_sys_i) disable iff (rst_i)
      address_qualifier_n_i |-> local_select_n_o;
   endproperty
   a_qual_blocks: assert property (p_qual_blocks) else $error("select with qualifier high");

   property p_ready_step;
      @(posedge clk_sys_i) disable iff (rst_i)
      !bclk_rise |=> $stable(sync_ready_n_o);
   endproperty
   a_ready_step: assert property (p_ready_step) else $error("sync ready moved off bus clock");

   property p_ready_fall;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bclk_rise && state_q == ST_WAIT && pend_q) |=> (!sync_ready_n_o && state_q == ST_READY);
   endproperty
   a_ready_fall: assert property (p_ready_fall) else $error("no ready fall on completion");

   property p_burst_wait;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bclk_rise && state_q == ST_BURST && sel_s && !pend_q) |=> !sync_ready_n_o;
   endproperty
   a_burst_wait: assert property (p_burst_wait) else $error("burst wait not low");

   property p_async_extend;
      @(posedge clk_sys_i) disable iff (rst_i)
      (async_active && !pend_q && !access_done_i) |=> async_ready_oe_o;
   endproperty
   a_async_extend: assert property (p_async_extend) else $error("async ready not extending");

   property p_async_release;
      @(posedge clk_sys_i) disable iff (rst_i)
      access_done_i |=> !async_ready_oe_o;
   endproperty
   a_async_release: assert property (p_async_release) else $error("async ready held after done");

   property p_strap_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
      strap_taken_q |=> (strap_taken_q && $stable(strap_q));
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

   property p_latch;
      @(posedge clk_sys_i) disable iff (rst_i)
      ads_rise |=> (latched_address_o == $past(addr_s) && latched_qualifier_n_o == $past(aq_n_s));
   endproperty
   a_latch: assert property (p_latch) else $error("address not latched");

   property p_mode;
      @(posedge clk_sys_i) disable iff (rst_i)
      strap_taken_q |-> (sync_local_bus_mode_o == !strap_q);
   endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");

   c_sync_done:  cover property (@(posedge clk_sys_i) disable iff (rst_i) state_q == ST_READY);
   c_burst_wait: cover property (@(posedge clk_sys_i) disable iff (rst_i)
                                 state_q == ST_BURST && !sync_ready_n_o);
   c_async_ext:  cover property (@(posedge clk_sys_i) disable iff (rst_i) async_ready_oe_o ##1 !async_ready_oe_o);
endmodule

/* host_bus_regs.svh */
// Constants of the host bus ready and decode block
`ifndef HOST_BUS_REGS_SVH
`define HOST_BUS_REGS_SVH
`define ADDR_MSB           15
`define ADDR_LSB           1
`define DECODE_LSB         4
`define STRAP_SYNC_MODE    1'b0
`define SYNC_STAGES        2
`define SYNC_READY_RST     1'b1
`endif

/* host_bus_pkg.sv */
// Types of the host bus ready and decode block
package host_bus_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_READY = 2'b10,
      ST_BURST = 2'b11
   } sync_state_e;
endpackage

/* pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // Reset to each pin's idle level, so no false edge follows reset
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_q <= pin_i;
         sync_o <= meta_q;
      end
   end
endmodule

/* host_bus_clock_model.sv */
// Host side bus clock model, idle low between accesses
`timescale 1ns/1ps
module host_bus_clock_model #(
   parameter int HALF_NS = 50
) (
   input  wire logic run_i,
   output logic      bus_clk_o
);
   initial begin
      bus_clk_o = 1'b0;
      forever begin
         wait (run_i === 1'b1);
         // Offset keeps bus edges clear of system clock edges
         #7;
         while (run_i === 1'b1) begin
            #(HALF_NS) bus_clk_o = 1'b1;
            #(HALF_NS) bus_clk_o = 1'b0;
         end
      end
   end
endmodule

/* test_host_bus_ready_decode.sv */
// Testbench of the host bus ready and decode block
`timescale 1ns/1ps
module test_host_bus_ready_decode;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        bus_run = 1'b0;
   logic        bus_clk_i;
   logic [15:1] address_i = '0;
   logic        address_qualifier_n_i = 1'b1, address_strobe_n_i = 1'b1;
   logic        async_read_strobe_n_i = 1'b1, async_write_strobe_n_i = 1'b1;
   logic        command_cycle_n_i = 1'b1, sync_write_not_read_i = 1'b0;
   logic        bus_mode_strap_n_i = 1'b0, burst_select_i = 1'b0, access_done_i = 1'b0;
   logic [15:0] base_address_i = 16'h1230, irq_status_i = '0;
   logic        local_select_n_o, local_select_n_oe_o, irq_out_n_o, irq_out_n_oe_o;
   logic        async_ready_o, async_ready_oe_o, sync_ready_n_o, extended_burst_mode_o;
   logic        sync_local_bus_mode_o, access_write_o, latched_qualifier_n_o;
   logic [15:1] latched_address_o;
   int          num_errors = 0, num_checks = 0, cycles = 0, n;

   always #12.5 clk_sys_i = ~clk_sys_i;

   host_bus_clock_model u_host_bus_clock_model (.run_i(bus_run), .bus_clk_o(bus_clk_i));

   host_bus_ready_decode u_host_bus_ready_decode (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_clk_i(bus_clk_i), .address_i(address_i),
      .address_qualifier_n_i(address_qualifier_n_i), .address_strobe_n_i(address_strobe_n_i),
      .async_read_strobe_n_i(async_read_strobe_n_i), .async_write_strobe_n_i(async_write_strobe_n_i),
      .command_cycle_n_i(command_cycle_n_i), .sync_write_not_read_i(sync_write_not_read_i),
      .bus_mode_strap_n_i(bus_mode_strap_n_i), .burst_select_i(burst_select_i),
      .base_address_i(base_address_i), .irq_status_i(irq_status_i), .access_done_i(access_done_i),
      .local_select_n_o(local_select_n_o), .local_select_n_oe_o(local_select_n_oe_o),
      .irq_out_n_o(irq_out_n_o), .irq_out_n_oe_o(irq_out_n_oe_o), .async_ready_o(async_ready_o),
      .async_ready_oe_o(async_ready_oe_o), .sync_ready_n_o(sync_ready_n_o),
      .extended_burst_mode_o(extended_burst_mode_o), .sync_local_bus_mode_o(sync_local_bus_mode_o),
      .access_write_o(access_write_o), .latched_address_o(latched_address_o),
      .latched_qualifier_n_o(latched_qualifier_n_o));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // A stalled handshake must not hang the run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic do_reset(input logic strap, input logic bsel);
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      bus_mode_strap_n_i <= strap;
      burst_select_i <= bsel;
      tick(3);
      @(posedge clk_sys_i);
      rst_i <= 1'b0;
      tick(4);
   endtask

   task automatic drive_addr(input logic [15:0] a, input logic q);
      @(posedge clk_sys_i);
      address_i <= a[15:1];
      address_qualifier_n_i <= q;
      #1;
   endtask

   task automatic pulse_done();
      @(posedge clk_sys_i);
      access_done_i <= 1'b1;
      @(posedge clk_sys_i);
      access_done_i <= 1'b0;
   endtask

   task automatic wait_ready(input logic lvl);
      for (n = 0; n < 40 && sync_ready_n_o !== lvl; n++) tick(1);
      chk("sync ready level", lvl, sync_ready_n_o);
   endtask

   task automatic test_decode();
      drive_addr(16'h1230, 1'b0);
      chk("select on match", 1'b0, local_select_n_o);
      drive_addr(16'h1230, 1'b1);
      chk("select qualifier high", 1'b1, local_select_n_o);
      drive_addr(16'h123E, 1'b0);
      chk("select low bits ignored", 1'b0, local_select_n_o);
      drive_addr(16'h1240, 1'b0);
      chk("select bit 4 differs", 1'b1, local_select_n_o);
      drive_addr(16'h9230, 1'b0);
      chk("select bit 15 differs", 1'b1, local_select_n_o);
      chk("select enable", 1'b1, local_select_n_oe_o);
      $display("test decode done");
   endtask

   task automatic test_irq();
      @(posedge clk_sys_i);
      irq_status_i <= 16'h8000;
      tick(2);
      chk("irq pulled low", 1'b1, irq_out_n_oe_o);
      chk("irq level", 1'b0, irq_out_n_o);
      @(posedge clk_sys_i);
      irq_status_i <= 16'h0000;
      tick(2);
      chk("irq released", 1'b0, irq_out_n_oe_o);
      $display("test irq done");
   endtask

   task automatic test_async();
      do_reset(1'b1, 1'b0);
      chk("async sync mode", 1'b0, sync_local_bus_mode_o);
      chk("async burst mode", 1'b0, extended_burst_mode_o);
      drive_addr(16'h1230, 1'b0);
      async_read_strobe_n_i <= 1'b0;
      for (n = 0; n < 10 && async_ready_oe_o !== 1'b1; n++) tick(1);
      chk("async extend", 1'b1, async_ready_oe_o);
      tick(5);
      chk("async still extended", 1'b1, async_ready_oe_o);
      chk("async ready level", 1'b0, async_ready_o);
      @(posedge clk_sys_i);
      access_done_i <= 1'b1;
      async_read_strobe_n_i <= 1'b1;
      @(posedge clk_sys_i);
      access_done_i <= 1'b0;
      tick(4);
      chk("async released", 1'b0, async_ready_oe_o);
      $display("test async done");
   endtask

   task automatic test_sync();
      do_reset(1'b0, 1'b0);
      chk("sync mode", 1'b1, sync_local_bus_mode_o);
      @(posedge clk_sys_i);
      bus_mode_strap_n_i <= 1'b1;
      tick(4);
      chk("strap held", 1'b1, sync_local_bus_mode_o);
      drive_addr(16'h1230, 1'b0);
      command_cycle_n_i <= 1'b0;
      sync_write_not_read_i <= 1'b1;
      bus_run <= 1'b1;
      tick(12);
      chk("sync no early ready", 1'b1, sync_ready_n_o);
      pulse_done();
      wait_ready(1'b0);
      chk("sync write direction", 1'b1, access_write_o);
      for (n = 0; n < 40 && sync_ready_n_o === 1'b0; n++) tick(1);
      chk("sync ready low span", 16'd4, n[15:0]);
      @(posedge clk_sys_i);
      command_cycle_n_i <= 1'b1;
      address_qualifier_n_i <= 1'b1;
      bus_run <= 1'b0;
      $display("test sync done");
   endtask

   task automatic test_burst();
      do_reset(1'b1, 1'b1);
      chk("burst mode", 1'b1, extended_burst_mode_o);
      drive_addr(16'h1230, 1'b0);
      address_strobe_n_i <= 1'b0;
      command_cycle_n_i <= 1'b1;
      bus_run <= 1'b1;
      wait_ready(1'b0);
      tick(12);
      chk("burst wait states", 1'b0, sync_ready_n_o);
      chk("burst read direction", 1'b0, access_write_o);
      pulse_done();
      wait_ready(1'b1);
      @(posedge clk_sys_i);
      address_qualifier_n_i <= 1'b1;
      address_strobe_n_i <= 1'b1;
      bus_run <= 1'b0;
      $display("test burst done");
   endtask

   task automatic test_latch();
      drive_addr(16'h4A5E, 1'b0);
      address_strobe_n_i <= 1'b0;
      tick(3);
      @(posedge clk_sys_i);
      address_strobe_n_i <= 1'b1;
      tick(6);
      chk("latched address", 16'h4A5E, {latched_address_o, 1'b0});
      chk("latched qualifier", 1'b0, latched_qualifier_n_o);
      $display("test latch done");
   endtask

   initial begin
      do_reset(1'b0, 1'b0);
      test_decode();
      test_irq();
      test_latch();
      test_async();
      test_sync();
      test_burst();
      report_and_stop();
   end
endmodule
